// *** core/sar_regs.svh ***
`ifndef SAR_REGS_SVH
`define SAR_REGS_SVH

// Frame layout, counted in serial clock falling edges
`define SAR_CNT_W 5
`define SAR_FRAME_CLKS 16
`define SAR_LEAD_ZEROS 4
`define SAR_MAX_RES 12
`define SAR_TRACK_FALL_WIDE 13
`define SAR_TRACK_FALL_8B 11
`define SAR_PD_FIRST_FALL 2
`define SAR_KEEP_FALL 10
`define SAR_WAKE_FULL_CLKS 16

`endif

// *** core/sar_pkg.sv ***
`default_nettype none
package sar_pkg;
    // Power mode of the converter, one-hot
    typedef enum logic [2:0] {
        SAR_NORMAL = 3'b001,
        SAR_WAKING = 3'b010,
        SAR_DOWN   = 3'b100
    } sar_mode_e;
endpackage
`default_nettype wire

// *** core/sar_edge_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface sar_edge_if;
    logic cs_n;
    logic cs_fall;
    logic cs_rise;
    logic sclk_fall;
    logic sclk_rise;
    modport src (output cs_n, output cs_fall, output cs_rise, output sclk_fall, output sclk_rise);
    modport dst (input cs_n, input cs_fall, input cs_rise, input sclk_fall, input sclk_rise);
endinterface
`default_nettype wire

// *** core/sar_pin_sync.sv ***
`timescale 1ns/100ps
`default_nettype none
module sar_pin_sync
    import sar_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic cs_n_in,
    input wire logic sclk_in,
    sar_edge_if.src edge_if
);
    logic cs_meta_q;
    logic cs_sync_q;
    logic cs_prev_q;
    logic sclk_meta_q;
    logic sclk_sync_q;
    logic sclk_prev_q;

    // Two-stage synchronisers, then one stage for edge finding
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cs_meta_q <= 1'b1;
            cs_sync_q <= 1'b1;
            cs_prev_q <= 1'b1;
            sclk_meta_q <= 1'b1; // Idle-high level, so no false edge follows reset
            sclk_sync_q <= 1'b1;
            sclk_prev_q <= 1'b1;
        end else begin
            cs_meta_q <= cs_n_in;
            cs_sync_q <= cs_meta_q;
            cs_prev_q <= cs_sync_q;
            sclk_meta_q <= sclk_in;
            sclk_sync_q <= sclk_meta_q;
            sclk_prev_q <= sclk_sync_q;
        end
    end

    // Select level and edge pulses, one cycle each
    assign edge_if.cs_n = cs_sync_q;
    assign edge_if.cs_fall = cs_prev_q & ~cs_sync_q;
    assign edge_if.cs_rise = ~cs_prev_q & cs_sync_q;
    assign edge_if.sclk_fall = sclk_prev_q & ~sclk_sync_q;
    assign edge_if.sclk_rise = ~sclk_prev_q & sclk_sync_q;
endmodule // sar_pin_sync
`default_nettype wire

// *** core/sar_readout.sv ***
// Contract
// - select falling holds the input, samples it, drives the line, starts conversion.
// - serial clock both paces the conversion and shifts result bits out.
// - 12-bit: 16 clocks; track after 13th fall; release on 16th fall.
// - 10-bit: 14 clocks; track on rise after the 13th fall.
// - 8-bit: 12 clocks; track on rise after the 11th fall.
// - select rising early aborts conversion and releases the data line.
// - a 16-clock frame on narrow variants releases the line on 16th fall.
// - select fall shows first zero; each clock fall shifts the next bit.
// - 12-bit last bit launched on 15th fall, still valid on 16th.
// - select falling just after a clock fall still shows the first zero.
// - waking from power-down, track resumes on first clock edge after select fall.
// - after supply the mode is either normal or power-down.
// - after supply the track-and-hold is already tracking.
// - select rising between 2nd and 10th fall aborts and powers down.
// - select rising after 10th fall but early aborts and stays powered.
// - waking needs select low past 10th fall; full after sixteen clocks (here select rising past 10th fall goes to normal at once).
// - 8-bit word is four leading zeros then eight bits, MSB first.
`timescale 1ns/100ps
`default_nettype none
`include "sar_regs.svh"
module sar_readout
    import sar_pkg::*;
#(
    parameter int RES_BITS = 12
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic cs_n_in,
    input wire logic sclk_in,
    input wire logic power_down_strap_in,
    input wire logic [RES_BITS-1:0] conv_result_in,
    output logic serial_result_out,
    output logic serial_result_oe_n_out,
    output logic track_out,
    output logic powered_out,
    output logic sample_strobe_out,
    output logic conv_done_out,
    output logic conv_abort_out
);
    localparam logic [`SAR_CNT_W-1:0] CNT_MAX = '1;
    localparam logic [`SAR_CNT_W-1:0] LAST_FALL = `SAR_CNT_W'(`SAR_FRAME_CLKS - 1);
    localparam logic [`SAR_CNT_W-1:0] CONV_CLKS = `SAR_CNT_W'(RES_BITS + `SAR_LEAD_ZEROS);
    localparam logic [`SAR_CNT_W-1:0] TRACK_FALL = (RES_BITS == 8) ?
        `SAR_CNT_W'(`SAR_TRACK_FALL_8B) : `SAR_CNT_W'(`SAR_TRACK_FALL_WIDE);
    localparam logic [`SAR_CNT_W-1:0] PD_FIRST = `SAR_CNT_W'(`SAR_PD_FIRST_FALL);
    localparam logic [`SAR_CNT_W-1:0] KEEP_FALL = `SAR_CNT_W'(`SAR_KEEP_FALL);
    localparam logic [`SAR_CNT_W-1:0] WAKE_FULL = `SAR_CNT_W'(`SAR_WAKE_FULL_CLKS);
    localparam int PAD = `SAR_MAX_RES - RES_BITS;

    logic rst_meta_q;
    logic rst_n_q;
    logic strap_meta_q;
    logic strap_q;
    logic strap_taken_q;
    logic [`SAR_CNT_W-1:0] cnt_q;
    logic [`SAR_FRAME_CLKS-1:0] shift_q;
    logic oe_n_q;
    logic track_q;
    logic busy_q;
    logic done_q;
    logic abort_q;
    logic sample_q;
    logic powered_q;
    logic waking_edge_q;
    sar_mode_e mode_q;
    logic [`SAR_FRAME_CLKS-1:0] frame_word;
    logic clk_fall_in_frame;

    sar_edge_if edge_if ();

    // Pin synchronisers and edge finders
    sar_pin_sync u_sync (
        .clk_in(clk_in),
        .rst_n_in(rst_n_q),
        .cs_n_in(cs_n_in),
        .sclk_in(sclk_in),
        .edge_if(edge_if)
    );

    // Reset release through two flip-flops
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    // Power-on mode strap, synchronised then caught once after release
    // No reset here: the strap must already be settled when the mode is taken
    always_ff @(posedge clk_in) begin
        strap_meta_q <= power_down_strap_in;
        strap_q <= strap_meta_q;
    end

    // Result left aligned below the four leading zeros, trailing zeros after
    assign frame_word = `SAR_FRAME_CLKS'(conv_result_in) << PAD;
    // A clock fall in the same cycle as the select fall belongs before the frame
    assign clk_fall_in_frame = edge_if.sclk_fall & ~edge_if.cs_n & ~edge_if.cs_fall;

    // Falling clock edge counter, cleared while select is high
    always_ff @(posedge clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            cnt_q <= '0;
        end else if (edge_if.cs_n || edge_if.cs_fall) begin
            cnt_q <= '0;
        end else if (clk_fall_in_frame && cnt_q != CNT_MAX) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // Output shifter: first zero at select fall, one bit per clock fall
    always_ff @(posedge clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            shift_q <= '0;
        end else if (edge_if.cs_fall) begin
            shift_q <= frame_word;
        end else if (clk_fall_in_frame) begin
            shift_q <= {shift_q[`SAR_FRAME_CLKS-2:0], 1'b0};
        end
    end

    // Data line enable
    always_ff @(posedge clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            oe_n_q <= 1'b1;
        end else if (edge_if.cs_fall) begin
            oe_n_q <= 1'b0;
        end else if (edge_if.cs_rise) begin
            oe_n_q <= 1'b1;
        end else if (clk_fall_in_frame && cnt_q == LAST_FALL) begin
            oe_n_q <= 1'b1;
        end
    end

    // Conversion progress, completion and abort pulses
    always_ff @(posedge clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            busy_q <= 1'b0;
            done_q <= 1'b0;
            abort_q <= 1'b0;
            sample_q <= 1'b0;
        end else begin
            sample_q <= edge_if.cs_fall;
            done_q <= 1'b0;
            abort_q <= 1'b0;
            if (edge_if.cs_fall) begin
                busy_q <= 1'b1;
            end else if (edge_if.cs_rise && busy_q) begin
                busy_q <= 1'b0;
                abort_q <= 1'b1;
            end else if (busy_q && clk_fall_in_frame && cnt_q == CONV_CLKS - 1'b1) begin
                busy_q <= 1'b0;
                done_q <= 1'b1;
            end
        end
    end

    // Remembers that the first clock edge of a waking frame was seen
    always_ff @(posedge clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            waking_edge_q <= 1'b0;
        end else if (edge_if.cs_n || edge_if.cs_fall) begin
            waking_edge_q <= 1'b0;
        end else if (edge_if.sclk_fall || edge_if.sclk_rise) begin
            waking_edge_q <= 1'b1;
        end
    end

    // Track-and-hold control; tracking from reset as after supply
    always_ff @(posedge clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            track_q <= 1'b1;
        end else if (edge_if.cs_fall) begin
            track_q <= 1'b0;
        end else if (edge_if.cs_rise) begin
            track_q <= 1'b1;
        end else if (!edge_if.cs_n && mode_q == SAR_WAKING && !waking_edge_q &&
                     (edge_if.sclk_fall || edge_if.sclk_rise)) begin
            track_q <= 1'b1;
        end else if (!edge_if.cs_n && edge_if.sclk_rise && cnt_q >= TRACK_FALL) begin
            track_q <= 1'b1;
        end
    end

    // Power mode machine; the strap picks the power-on mode
    always_ff @(posedge clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            mode_q <= SAR_NORMAL;
            strap_taken_q <= 1'b0;
        end else if (!strap_taken_q) begin
            strap_taken_q <= 1'b1;
            mode_q <= strap_q ? SAR_DOWN : SAR_NORMAL;
        end else begin
            case (mode_q)
                SAR_NORMAL: begin
                    if (edge_if.cs_rise && cnt_q >= PD_FIRST && cnt_q < KEEP_FALL) begin
                        mode_q <= SAR_DOWN;
                    end
                end
                SAR_DOWN: begin
                    if (edge_if.cs_fall) begin
                        mode_q <= SAR_WAKING;
                    end
                end
                SAR_WAKING: begin
                    if (edge_if.cs_rise && cnt_q < KEEP_FALL) begin
                        mode_q <= SAR_DOWN;
                    end else if (edge_if.cs_rise) begin
                        mode_q <= SAR_NORMAL;
                    end else if (clk_fall_in_frame && cnt_q == WAKE_FULL - 1'b1) begin
                        mode_q <= SAR_NORMAL;
                    end
                end
                default: begin
                    mode_q <= SAR_NORMAL;
                end
            endcase
        end
    end

    // Fully powered flag, registered from the current mode once the strap is taken
    always_ff @(posedge clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            powered_q <= 1'b0;
        end else begin
            powered_q <= (mode_q == SAR_NORMAL) && strap_taken_q;
        end
    end

    // Outputs straight from flip-flops
    assign serial_result_out = shift_q[`SAR_FRAME_CLKS-1];
    assign serial_result_oe_n_out = oe_n_q;
    assign track_out = track_q;
    assign powered_out = powered_q;
    assign sample_strobe_out = sample_q;
    assign conv_done_out = done_q;
    assign conv_abort_out = abort_q;
endmodule // sar_readout
`default_nettype wire

// *** verification/sar_readout_sva.sv ***
`timescale 1ns/100ps
`default_nettype none
module sar_readout_sva #(
    parameter int RES_BITS = 12
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic cs_n_in,
    input wire logic sclk_in,
    input wire logic power_down_strap_in,
    input wire logic [RES_BITS-1:0] conv_result_in,
    input wire logic serial_result_out,
    input wire logic serial_result_oe_n_out,
    input wire logic track_out,
    input wire logic powered_out,
    input wire logic sample_strobe_out,
    input wire logic conv_done_out,
    input wire logic conv_abort_out
);
    // One clock domain; checks pause while reset is low
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!reset_n_in);
    // Pin relations, allowing for the synchroniser latency
    AST_OE_ON: assert property ($fell(cs_n_in) |-> ##[2:5]
        (!serial_result_oe_n_out && !serial_result_out && !track_out))
        else $error("line not driven low in hold after select fall");
    AST_STROBE: assert property (sample_strobe_out |-> ##[0:1] !serial_result_oe_n_out)
        else $error("sample strobe without driven line");
    AST_OE_IDLE: assert property (cs_n_in [*5] |-> serial_result_oe_n_out)
        else $error("line driven while select high");
    AST_TRACK_IDLE: assert property (cs_n_in [*5] |-> track_out)
        else $error("hold while select high");
    AST_DONE: assert property (conv_done_out |-> !cs_n_in ##1 !conv_done_out)
        else $error("done pulse outside a frame or too long");
    AST_ABORT: assert property (conv_abort_out |-> cs_n_in && $past(cs_n_in, 2))
        else $error("abort without select rise");
    AST_PD: assert property ($fell(powered_out) |-> cs_n_in)
        else $error("power dropped while select low");
    AST_DATA: assert property ((sclk_in && !serial_result_oe_n_out) [*3]
        |-> $stable(serial_result_out))
        else $error("data moved while clock high");
endmodule // sar_readout_sva
`default_nettype wire

// *** verification/sar_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module sar_host_model (
    input wire logic clk_in,
    input wire logic data_in,
    input wire logic data_oe_n_in,
    output logic cs_n_out,
    output logic sclk_out
);
    logic last_q;
    logic line_w;
    logic [15:0] rise_word;
    // Released line shows the inverse of the last driven bit
    always_ff @(posedge clk_in) begin
        if (!data_oe_n_in) last_q <= data_in;
    end
    assign line_w = data_oe_n_in ? ~last_q : data_in;
    // Select and clock idle high; clock stands still outside frames
    initial begin
        cs_n_out = 1'b1;
        sclk_out = 1'b1;
    end
    // Advance n clock edges, then step just past the edge
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    // One frame of n clock falls, 200 ns period; line captured at each fall
    // A second copy is captured just before each rise up to the 15th, as a slow host may do
    task automatic frame(input int n, output logic [15:0] word, output logic oe_end);
        word = 16'hFFFF;
        rise_word = 16'hFFFF;
        wait_clk(1);
        cs_n_out = 1'b0;
        wait_clk(4);
        for (int k = 1; k <= n; k++) begin
            word[16-k] = line_w;
            sclk_out = 1'b0;
            wait_clk(4);
            if (k < 16) rise_word[15-k] = line_w;
            sclk_out = 1'b1;
            wait_clk(4);
        end
        oe_end = data_oe_n_in;
        cs_n_out = 1'b1;
        wait_clk(8);
    endtask
endmodule // sar_host_model
`default_nettype wire

// *** verification/sar_readout_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
bind sar_readout sar_readout_sva #(.RES_BITS(RES_BITS)) u_sva (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .cs_n_in(cs_n_in),
    .sclk_in(sclk_in),
    .power_down_strap_in(power_down_strap_in),
    .conv_result_in(conv_result_in),
    .serial_result_out(serial_result_out),
    .serial_result_oe_n_out(serial_result_oe_n_out),
    .track_out(track_out),
    .powered_out(powered_out),
    .sample_strobe_out(sample_strobe_out),
    .conv_done_out(conv_done_out),
    .conv_abort_out(conv_abort_out)
);
module sar_readout_tb;
    logic clk_in, reset_n_in, cs_n_in, sclk_in, power_down_strap_in;
    logic [11:0] conv_result_in;
    logic serial_result_out, serial_result_oe_n_out, track_out, powered_out;
    logic sample_strobe_out, conv_done_out, conv_abort_out;
    logic cs8_n, sclk8, data8, oe8_n, powered8;
    logic [7:0] res8;
    logic [15:0] word;
    logic oe_end;
    int err_count;
    int n_checks;
    // Converter under test with a 12-bit result, host on the far side
    sar_readout #(.RES_BITS(12)) DUT (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .cs_n_in(cs_n_in),
        .sclk_in(sclk_in),
        .power_down_strap_in(power_down_strap_in),
        .conv_result_in(conv_result_in),
        .serial_result_out(serial_result_out),
        .serial_result_oe_n_out(serial_result_oe_n_out),
        .track_out(track_out),
        .powered_out(powered_out),
        .sample_strobe_out(sample_strobe_out),
        .conv_done_out(conv_done_out),
        .conv_abort_out(conv_abort_out)
    );
    // Narrow 8-bit variant with a host of its own
    sar_readout #(.RES_BITS(8)) DUT8 (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .cs_n_in(cs8_n),
        .sclk_in(sclk8),
        .power_down_strap_in(power_down_strap_in),
        .conv_result_in(res8),
        .serial_result_out(data8),
        .serial_result_oe_n_out(oe8_n),
        .track_out(),
        .powered_out(powered8),
        .sample_strobe_out(),
        .conv_done_out(),
        .conv_abort_out()
    );
    sar_host_model host8 (
        .clk_in(clk_in),
        .data_in(data8),
        .data_oe_n_in(oe8_n),
        .cs_n_out(cs8_n),
        .sclk_out(sclk8)
    );
    sar_host_model host (
        .clk_in(clk_in),
        .data_in(serial_result_out),
        .data_oe_n_in(serial_result_oe_n_out),
        .cs_n_out(cs_n_in),
        .sclk_out(sclk_in)
    );
    // 40 MHz system clock
    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end
    // Compare, count and report a mismatch
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tally_and_finish();
        if (err_count == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Hold reset for 8 clocks with the chosen power-on mode
    task automatic do_reset(input logic strap);
        reset_n_in = 1'b0;
        power_down_strap_in = strap;
        host.wait_clk(8);
        reset_n_in = 1'b1;
        host.wait_clk(10);
    endtask
    // Full frames: four zeros, then the result, line released on the 16th fall
    task automatic t_full_frame();
        conv_result_in = 12'hA5C;
        host.frame(16, word, oe_end);
        check("word", 16'h0A5C, word);
        check("release", 16'h0001, {15'h0, oe_end});
        check("rise_word", 16'h8A5C, host.rise_word);
        conv_result_in = 12'hFFF;
        host.frame(16, word, oe_end);
        check("word_max", 16'h0FFF, word);
    endtask
    // Cut after 12 falls: line held until select rises, power kept
    task automatic t_abort();
        conv_result_in = 12'h3C6;
        host.frame(12, word, oe_end);
        check("word_part", 16'h03CF, word);
        check("held", 16'h0000, {15'h0, oe_end});
        check("oe_n", 16'h0001, {15'h0, serial_result_oe_n_out});
        check("powered", 16'h0001, {15'h0, powered_out});
    endtask
    // Select rise after 1, 5, 9 and 11 falls steers the power mode
    task automatic t_power();
        int falls[4] = '{1, 5, 9, 11};
        logic pw[4] = '{1'b1, 1'b0, 1'b0, 1'b1};
        for (int i = 0; i < 4; i++) begin
            host.frame(falls[i], word, oe_end);
            check("powered", {15'h0, pw[i]}, {15'h0, powered_out});
        end
    endtask
    // Narrow variant: four zeros, eight bits, trailing zeros; 16 or 12 clocks
    task automatic t_narrow();
        res8 = 8'hB7;
        host8.frame(16, word, oe_end);
        check("word8", 16'h0B70, word);
        check("release8", 16'h0001, {15'h0, oe_end});
        host8.frame(12, word, oe_end);
        check("word8_short", 16'h0B7F, word);
        check("held8", 16'h0000, {15'h0, oe_end});
        check("oe_n8", 16'h0001, {15'h0, oe8_n});
        check("powered8", 16'h0001, {15'h0, powered8});
    endtask
    // Come up powered down, wake with one dummy frame, then a valid read
    task automatic t_strap();
        do_reset(1'b1);
        check("pd_start", 16'h0000, {15'h0, powered_out});
        check("track", 16'h0001, {15'h0, track_out});
        host.frame(16, word, oe_end);
        check("woken", 16'h0001, {15'h0, powered_out});
        conv_result_in = 12'h5A3;
        host.frame(16, word, oe_end);
        check("word_awake", 16'h05A3, word);
    endtask
    // Main sequence
    initial begin
        reset_n_in = 1'b0;
        power_down_strap_in = 1'b0;
        conv_result_in = 12'h000;
        res8 = 8'h00;
        err_count = 0;
        n_checks = 0;
        do_reset(1'b0);
        t_full_frame();
        t_narrow();
        t_abort();
        t_power();
        t_strap();
        tally_and_finish();
    end
    // Watchdog cuts a hang short
    initial begin
        #200000;
        err_count++;
        tally_and_finish();
    end
endmodule // sar_readout_tb
`default_nettype wire
